// File: inc/htc_defs.vh
`ifndef HTC_DEFS_VH
`define HTC_DEFS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HTC_A_CTRL 8'h00
`define HTC_A_SETPT 8'h04
`define HTC_A_DBAND 8'h08
`define HTC_A_TEMP 8'h0C
`define HTC_A_CURR 8'h10
`define HTC_A_HILVL 8'h14
`define HTC_A_LOLVL 8'h18
`define HTC_A_CURVE_A 8'h1C
`define HTC_A_CURVE_B 8'h20
`define HTC_A_MODNUM 8'h24
`define HTC_A_STATUS 8'h28
`define HTC_A_SLOPE 8'h2C
`define HTC_A_MEANERR 8'h30
`define HTC_A_RATIO 8'h34
// ****************************************
// control register fields
// ****************************************
`define HTC_C_PROP 0
`define HTC_C_BYPASS_EN 1
`define HTC_C_HEAT_OFF 2
`define HTC_C_CURVE_EN 3
`define HTC_C_CONTACT_NC 4
`define HTC_C_LAMP_LO 5
`define HTC_C_LAMP_HI 6
`define HTC_C_RESET 32'h0000_0000
// ****************************************
// status register fields
// ****************************************
`define HTC_S_HEAT 0
`define HTC_S_HI_ALARM 1
`define HTC_S_LO_ALARM 2
`define HTC_S_WINDOW 3
`define HTC_S_REJECT 4
`define HTC_S_DUTY_LSB 8
// ****************************************
// constants
// ****************************************
`define HTC_CLK_HZ 100000000
`define HTC_HOUR_S 3600
`define HTC_WINDOW_S 120
`define HTC_FLASH_CYC 25'h17D7840
`define HTC_SLOPE_MIN 4'h1
`define HTC_SLOPE_MAX 4'hA
`define HTC_SLOPE_INIT 4'h5
`define HTC_FRAME 4'hA
`define HTC_RATIO_ONE 16'h0100
`endif

// File: src/htc_cycle_mod.v
// ****************************************
// whole-cycle modulator, ten-cycle frame
// ****************************************
`include "htc_defs.vh"
module htc_cycle_mod (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // mains zero-cross pulse and demand
    input wire zero_cross,
    input wire [3:0] duty_tenths,
    // heater gate
    output reg heater_on_ff
);
    reg [3:0] slot_ff;
    reg [3:0] acc_ff;
    reg [3:0] nxt_slot;
    reg [4:0] sum;
    always @* begin
        sum = {1'b0, acc_ff} + {1'b0, duty_tenths};
        nxt_slot = (slot_ff == `HTC_FRAME - 4'h1) ? 4'h0 : slot_ff + 4'h1;
    end
    // spread the on cycles evenly: a bresenham accumulator per mains cycle
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slot_ff <= 4'h0;
            acc_ff <= 4'h0;
            heater_on_ff <= 1'b0;
        end else if (zero_cross) begin
            slot_ff <= nxt_slot;
            if (sum >= {1'b0, `HTC_FRAME}) begin
                acc_ff <= sum[3:0] - `HTC_FRAME;
                heater_on_ff <= 1'b1;
            end else begin
                acc_ff <= (slot_ff == `HTC_FRAME - 4'h1) ? 4'h0 : sum[3:0];
                heater_on_ff <= 1'b0;
            end
        end
    end
endmodule

// File: src/htc_lamp_flash.v
// ****************************************
// activity lamp: stretched blink
// ****************************************
`include "htc_defs.vh"
module htc_lamp_flash (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // activity pulse
    input wire activity,
    // lamp
    output reg lamp_ff
);
    reg [24:0] cnt_ff;
    // a short burst would be invisible, so a pulse seen while the lamp is dark starts a blink period
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 25'h0;
            lamp_ff <= 1'b0;
        end else if (cnt_ff != 25'h0) begin
            cnt_ff <= cnt_ff - 25'h1;
            if (cnt_ff == 25'h1) begin
                lamp_ff <= 1'b0;
            end
        end else if (activity) begin
            cnt_ff <= `HTC_FLASH_CYC;
            lamp_ff <= 1'b1;
        end
    end
endmodule

// File: src/htc_top.v
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`include "htc_defs.vh"
module htc_top #(
    parameter [38:0] HOUR_CYC = 39'd360000000000,
    parameter [34:0] WINDOW_CYC = 35'd12000000000
) (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // measurements: temperature in signed tenths of degrees F, current in counts
    input wire [15:0] temp_value,
    input wire temp_valid,
    input wire [15:0] current_value,
    input wire zero_cross,
    // switches and bypass terminals
    input wire addr_change_switch,
    input wire program_lock_switch,
    input wire bypass_input,
    // serial activity pulses
    input wire tx_active,
    input wire rx_active,
    // outputs
    output wire heater_gate,
    output reg alarm_contact_ff,
    output reg alarm_lamp_ff,
    output wire addr_window_lamp,
    output wire tx_activity_lamp,
    output wire rx_activity_lamp,
    output reg bypass_lamp_ff
);
    // ****************************************
    // bus slave
    // ****************************************
    reg [31:0] ctrl_ff;
    reg [15:0] setpt_ff;
    reg [15:0] dband_ff;
    reg [15:0] hilvl_ff;
    reg [15:0] lolvl_ff;
    reg [15:0] curve_a_ff;
    reg [15:0] curve_b_ff;
    reg [7:0] modnum_ff;
    reg reject_ff;
    reg ack_ff;
    reg window_ff;
    reg [34:0] win_cnt_ff;
    reg sw_prev_ff;
    reg [3:0] slope_ff;
    reg [15:0] mean_err_ff;
    reg [15:0] ratio_ff;
    reg heat_ff;
    reg hi_alarm_ff;
    reg lo_alarm_ff;
    wire [3:0] duty;
    wire cfg_sel;
    wire wr_now;
    // one wait state per access; answer on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_now = avs_write & ack_ff;
    assign cfg_sel = (avs_address == `HTC_A_CTRL) | (avs_address == `HTC_A_SETPT) |
                     (avs_address == `HTC_A_DBAND) | (avs_address == `HTC_A_HILVL) |
                     (avs_address == `HTC_A_LOLVL) | (avs_address == `HTC_A_CURVE_A) |
                     (avs_address == `HTC_A_CURVE_B);
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            ctrl_ff <= `HTC_C_RESET;
            setpt_ff <= 16'h0000;
            dband_ff <= 16'h0000;
            hilvl_ff <= 16'hFFFF;
            lolvl_ff <= 16'h0000;
            curve_a_ff <= 16'h0000;
            curve_b_ff <= 16'h0000;
            modnum_ff <= 8'h01;
            reject_ff <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            if (wr_now && cfg_sel) begin
                if (!program_lock_switch) begin
                    reject_ff <= 1'b1;
                end else begin
                    case (avs_address)
                        `HTC_A_CTRL: ctrl_ff <= avs_writedata;
                        `HTC_A_SETPT: setpt_ff <= avs_writedata[15:0];
                        `HTC_A_DBAND: dband_ff <= avs_writedata[15:0];
                        `HTC_A_HILVL: hilvl_ff <= avs_writedata[15:0];
                        `HTC_A_LOLVL: lolvl_ff <= avs_writedata[15:0];
                        `HTC_A_CURVE_A: curve_a_ff <= avs_writedata[15:0];
                        default: curve_b_ff <= avs_writedata[15:0];
                    endcase
                end
            end else if (wr_now && avs_address == `HTC_A_MODNUM) begin
                if (window_ff) begin
                    modnum_ff <= avs_writedata[7:0];
                end else begin
                    reject_ff <= 1'b1;
                end
            end else if (wr_now && avs_address == `HTC_A_STATUS && avs_writedata[`HTC_S_REJECT]) begin
                reject_ff <= 1'b0;
            end
            if (avs_read & ~ack_ff) begin
                case (avs_address)
                    `HTC_A_CTRL: avs_readdata <= ctrl_ff;
                    `HTC_A_SETPT: avs_readdata <= {16'h0, setpt_ff};
                    `HTC_A_DBAND: avs_readdata <= {16'h0, dband_ff};
                    `HTC_A_TEMP: avs_readdata <= {16'h0, temp_value};
                    `HTC_A_CURR: avs_readdata <= {16'h0, current_value};
                    `HTC_A_HILVL: avs_readdata <= {16'h0, hilvl_ff};
                    `HTC_A_LOLVL: avs_readdata <= {16'h0, lolvl_ff};
                    `HTC_A_CURVE_A: avs_readdata <= {16'h0, curve_a_ff};
                    `HTC_A_CURVE_B: avs_readdata <= {16'h0, curve_b_ff};
                    `HTC_A_MODNUM: avs_readdata <= {24'h0, modnum_ff};
                    `HTC_A_STATUS: avs_readdata <= {20'h0, duty, 3'h0, reject_ff, window_ff,
                                                    lo_alarm_ff, hi_alarm_ff, heat_ff};
                    `HTC_A_SLOPE: avs_readdata <= {28'h0, slope_ff};
                    `HTC_A_MEANERR: avs_readdata <= {16'h0, mean_err_ff};
                    `HTC_A_RATIO: avs_readdata <= {16'h0, ratio_ff};
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************
    // address-change window
    // ****************************************
    assign addr_window_lamp = window_ff;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sw_prev_ff <= 1'b0;
            window_ff <= 1'b0;
            win_cnt_ff <= 35'h0;
        end else begin
            sw_prev_ff <= addr_change_switch;
            if (!addr_change_switch) begin
                window_ff <= 1'b0;
                win_cnt_ff <= 35'h0;
            end else if (!sw_prev_ff) begin
                window_ff <= 1'b1;
                win_cnt_ff <= WINDOW_CYC;
            end else if (win_cnt_ff != 35'h0) begin
                win_cnt_ff <= win_cnt_ff - 35'h1;
                window_ff <= (win_cnt_ff != 35'h1);
            end
        end
    end

    // ****************************************
    // error and on/off deadband control
    // ****************************************
    wire signed [16:0] err = $signed({setpt_ff[15], setpt_ff}) - $signed({temp_value[15], temp_value});
    wire [16:0] abs_err = err[16] ? (~err + 17'h1) : err;
    wire signed [16:0] db_s = $signed({1'b0, dband_ff});
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            heat_ff <= 1'b0;
        end else if (temp_valid) begin
            if (dband_ff == 16'h0) begin
                if (err > 0) heat_ff <= 1'b1;
                else if (err < 0) heat_ff <= 1'b0;
            end else if (heat_ff && -err >= db_s) begin
                heat_ff <= 1'b0;
            end else if (!heat_ff && err >= db_s) begin
                heat_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // proportional duty
    // ****************************************
    // duty tenths = round(10*err/slope); a small divide table by slope value
    reg [3:0] prop_duty;
    // a row of compares keeps a true divider out of the duty path
    integer k;
    always @* begin
        prop_duty = 4'h0;
        if (err <= 0) begin
            prop_duty = 4'h0;
        end else if (abs_err >= {13'h0, slope_ff}) begin
            prop_duty = `HTC_FRAME;
        end else begin
            for (k = 1; k < 10; k = k + 1) begin
                // tenths k chosen when 10*err >= (k-0.5)*slope, i.e. nearest step
                if (abs_err * 20 >= (2 * k - 1) * slope_ff) prop_duty = k[3:0];
            end
        end
    end
    // status heat bit shows the on/off call even in proportional mode
    wire [3:0] ctl_duty = ctrl_ff[`HTC_C_PROP] ? prop_duty : (heat_ff ? `HTC_FRAME : 4'h0);
    // bypass terminals: high means closed (shorted)
    reg [3:0] final_duty;
    always @* begin
        final_duty = ctl_duty;
        if (ctrl_ff[`HTC_C_BYPASS_EN]) begin
            if (!bypass_input) final_duty = 4'h0;
            else if (ctrl_ff[`HTC_C_HEAT_OFF]) final_duty = `HTC_FRAME;
            else final_duty = ctl_duty;
        end else if (ctrl_ff[`HTC_C_HEAT_OFF]) begin
            final_duty = 4'h0;
        end
    end
    assign duty = final_duty;
    htc_cycle_mod u_mod (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .zero_cross(zero_cross),
        .duty_tenths(final_duty),
        .heater_on_ff(heater_gate)
    );

    // ****************************************
    // hourly slope tuning
    // ****************************************
    reg [38:0] hour_cnt_ff;
    reg [31:0] err_sum_ff;
    reg [23:0] n_read_ff;
    reg [15:0] prev_mean_ff;
    reg have_prev_ff;
    reg dir_up_ff;
    wire [31:0] mean_full = (n_read_ff == 24'h0) ? 32'h0 : err_sum_ff / {8'h0, n_read_ff};
    wire [15:0] this_mean = mean_full[15:0];
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hour_cnt_ff <= 39'h0;
            err_sum_ff <= 32'h0;
            n_read_ff <= 24'h0;
            prev_mean_ff <= 16'h0;
            mean_err_ff <= 16'h0;
            have_prev_ff <= 1'b0;
            dir_up_ff <= 1'b1;
            slope_ff <= `HTC_SLOPE_INIT;
        end else if (hour_cnt_ff == HOUR_CYC - 39'h1) begin
            hour_cnt_ff <= 39'h0;
            err_sum_ff <= 32'h0;
            n_read_ff <= 24'h0;
            mean_err_ff <= this_mean;
            prev_mean_ff <= this_mean;
            have_prev_ff <= 1'b1;
            if (have_prev_ff && this_mean != prev_mean_ff) begin
                if ((this_mean < prev_mean_ff) == dir_up_ff) begin
                    dir_up_ff <= 1'b1;
                    if (slope_ff != `HTC_SLOPE_MAX) slope_ff <= slope_ff + 4'h1;
                end else begin
                    dir_up_ff <= 1'b0;
                    if (slope_ff != `HTC_SLOPE_MIN) slope_ff <= slope_ff - 4'h1;
                end
            end
        end else begin
            hour_cnt_ff <= hour_cnt_ff + 39'h1;
            if (temp_valid) begin
                err_sum_ff <= err_sum_ff + {15'h0, abs_err};
                n_read_ff <= n_read_ff + 24'h1;
            end
        end
    end

    // ****************************************
    // wattage correction and current alarms
    // ****************************************
    // ratio in 8.8 fixed point; the divider is large but runs combinationally, reloading ratio_ff every clock
    wire signed [33:0] w_set = $signed(curve_a_ff) * $signed(setpt_ff) + $signed({curve_b_ff, 4'h0} * 10);
    wire signed [33:0] w_now = $signed(curve_a_ff) * $signed(temp_value) + $signed({curve_b_ff, 4'h0} * 10);
    wire curve_ok = ctrl_ff[`HTC_C_CURVE_EN] && w_now > 0 && w_set > 0;
    wire [41:0] ratio_full = curve_ok ? ({w_set[33:0], 8'h0} / {8'h0, w_now[33:0]}) : 42'h0;
    wire [31:0] hi_scaled = hilvl_ff * ratio_ff;
    wire [31:0] lo_scaled = lolvl_ff * ratio_ff;
    reg flash_ff;
    reg [24:0] flash_cnt_ff;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ratio_ff <= `HTC_RATIO_ONE;
            hi_alarm_ff <= 1'b0;
            lo_alarm_ff <= 1'b0;
            alarm_contact_ff <= 1'b0;
            alarm_lamp_ff <= 1'b0;
            bypass_lamp_ff <= 1'b0;
            flash_ff <= 1'b0;
            flash_cnt_ff <= 25'h0;
        end else begin
            if (!curve_ok) ratio_ff <= `HTC_RATIO_ONE;
            else if (ratio_full > 42'hFFFF) ratio_ff <= 16'hFFFF;
            else ratio_ff <= ratio_full[15:0];
            hi_alarm_ff <= ({8'h0, current_value, 8'h0} > hi_scaled);
            lo_alarm_ff <= heater_gate && ({8'h0, current_value, 8'h0} < lo_scaled);
            flash_cnt_ff <= (flash_cnt_ff == 25'h0) ? `HTC_FLASH_CYC : flash_cnt_ff - 25'h1;
            if (flash_cnt_ff == 25'h0) flash_ff <= ~flash_ff;
            alarm_contact_ff <= (hi_alarm_ff | lo_alarm_ff) ^ ctrl_ff[`HTC_C_CONTACT_NC];
            case (ctrl_ff[`HTC_C_LAMP_HI:`HTC_C_LAMP_LO])
                2'h0: alarm_lamp_ff <= hi_alarm_ff | lo_alarm_ff;
                2'h1: alarm_lamp_ff <= ~(hi_alarm_ff | lo_alarm_ff);
                default: alarm_lamp_ff <= (hi_alarm_ff | lo_alarm_ff) & flash_ff;
            endcase
            bypass_lamp_ff <= bypass_input;
        end
    end

    // ****************************************
    // serial activity lamps
    // ****************************************
    htc_lamp_flash u_tx (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .activity(tx_active),
        .lamp_ff(tx_activity_lamp)
    );
    htc_lamp_flash u_rx (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .activity(rx_active),
        .lamp_ff(rx_activity_lamp)
    );
endmodule

// File: sim/htc_top_sva.sv
// ****
// port checker
// ****
module htc_chk #(
    parameter [34:0] WINDOW_CYC = 35'd50
) (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // heater
    input wire zero_cross,
    input wire heater_gate,
    // switches and lamps
    input wire addr_change_switch,
    input wire addr_window_lamp,
    input wire bypass_input,
    input wire bypass_lamp_ff,
    input wire tx_active,
    input wire rx_active,
    input wire tx_activity_lamp,
    input wire rx_activity_lamp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [35:0] win_cnt_ff;
    // counts how long the address lamp has stood lit
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) win_cnt_ff <= 36'h0;
        else win_cnt_ff <= addr_window_lamp ? win_cnt_ff + 36'h1 : 36'h0;
    end
    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    property p_gate_zc;
        heater_gate != $past(heater_gate) |-> $past(zero_cross);
    endproperty
    property p_byp_lamp;
        1'b1 |=> bypass_lamp_ff == $past(bypass_input);
    endproperty
    property p_tx_lamp;
        $rose(tx_active) |-> ##[1:2] tx_activity_lamp;
    endproperty
    property p_rx_lamp;
        $rose(rx_active) |-> ##[1:2] rx_activity_lamp;
    endproperty
    property p_win_open;
        $rose(addr_change_switch) |-> ##[1:3] addr_window_lamp;
    endproperty
    property p_win_shut;
        !addr_change_switch [*3] |-> !addr_window_lamp;
    endproperty
    property p_win_len;
        win_cnt_ff <= {1'b0, WINDOW_CYC} + 36'h2;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("second wait state seen");
    a_wait_first: assert property (p_wait_first) else $error("request taken without wait");
    a_gate_zc: assert property (p_gate_zc) else $error("heater moved off zero cross");
    a_byp_lamp: assert property (p_byp_lamp) else $error("bypass lamp wrong");
    a_tx_lamp: assert property (p_tx_lamp) else $error("tx lamp dark");
    a_rx_lamp: assert property (p_rx_lamp) else $error("rx lamp dark");
    a_win_open: assert property (p_win_open) else $error("window lamp dark");
    a_win_shut: assert property (p_win_shut) else $error("window lamp lit, switch off");
    a_win_len: assert property (p_win_len) else $error("window too long");
    c_write: cover property (avs_write && !avs_waitrequest);
    c_heat: cover property ($rose(heater_gate));
    c_win: cover property ($fell(addr_window_lamp));
endmodule
bind htc_top htc_chk #(.WINDOW_CYC(WINDOW_CYC)) htc_chk_i (.clk_sys(clk_sys), .nrst(nrst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .zero_cross(zero_cross), .heater_gate(heater_gate), .addr_change_switch(addr_change_switch),
    .addr_window_lamp(addr_window_lamp), .bypass_input(bypass_input), .bypass_lamp_ff(bypass_lamp_ff),
    .tx_active(tx_active), .rx_active(rx_active), .tx_activity_lamp(tx_activity_lamp),
    .rx_activity_lamp(rx_activity_lamp));

// File: sim/htc_mains_model.sv
// ****
// free-running mains and heater switch
// ****
module htc_mains_model #(
    parameter int ZC_CYC = 20
) (
    // clock and reset
    input logic clk_sys,
    input logic nrst,
    // mains and heater
    output logic zero_cross,
    input logic heater_gate,
    output logic [3:0] on_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph;
    logic zc_d;
    logic [9:0] hist;
    // on cycles in the last ten mains cycles; any ten cycles span one frame
    assign on_cnt = 4'($countones(hist));
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ph <= 0;
            zero_cross <= 1'b0;
            zc_d <= 1'b0;
            hist <= 10'h0;
        end else begin
            ph <= (ph == ZC_CYC - 1) ? 0 : ph + 1;
            zero_cross <= (ph == 0);
            zc_d <= zero_cross;
            // the gate settles one edge after the crossing
            if (zc_d) hist <= {hist[8:0], heater_gate};
        end
    end
endmodule

// File: sim/heat_trace_control_logic_tb.sv
`include "htc_defs.vh"
module heat_trace_control_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] e; logic [31:0] m;} htc_note_t;
    localparam int HOUR = 10000;
    logic clk_sys = 1'b0, nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, temp_valid = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, zero_cross, heater_gate, alarm_contact_ff, alarm_lamp_ff;
    logic [15:0] temp_value = 16'h0, current_value = 16'h0;
    logic addr_change_switch = 1'b0, program_lock_switch = 1'b0, bypass_input = 1'b0;
    logic tx_active = 1'b0, rx_active = 1'b0;
    logic addr_window_lamp, tx_activity_lamp, rx_activity_lamp, bypass_lamp_ff;
    logic [3:0] on_cnt;
    int n_errors = 0, checks = 0, cyc = 0, i, k, seed = 32'h3FB02BEB;
    int er[7] = '{0, 1, 2, 3, 5, 7, -3};
    int dt[7] = '{0, 2, 4, 6, 10, 10, 0};
    int he[3] = '{0, 5, 1};
    int hs[3] = '{6, 5, 4};
    htc_note_t q[$];
    always #5 clk_sys = ~clk_sys;
    htc_top #(.HOUR_CYC(39'h2710), .WINDOW_CYC(35'h32)) htc_top_i (.clk_sys, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .temp_value,
        .temp_valid, .current_value, .zero_cross, .addr_change_switch, .program_lock_switch,
        .bypass_input, .tx_active, .rx_active, .heater_gate, .alarm_contact_ff, .alarm_lamp_ff,
        .addr_window_lamp, .tx_activity_lamp, .rx_activity_lamp, .bypass_lamp_ff);
    htc_mains_model htc_mains_model_i (.clk_sys, .nrst, .zero_cross, .heater_gate, .on_cnt);
    // ****
    // checking and closing
    // ****
    task results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    // read data stand at the completing edge; take them there
    always @(posedge clk_sys) begin
        htc_note_t n;
        if (avs_read && avs_waitrequest === 1'b0) begin
            n = q.pop_front();
            chk($sformatf("reg %h", n.a), n.e & n.m, avs_readdata & n.m);
        end
    end
    always @(posedge clk_sys) begin
        if (nrst) cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            results;
        end
    end
    // ****
    // bus and stimulus tasks
    // ****
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{a, e, m});
        bus(1'b0, a, 32'h0);
    endtask
    task tmp(input logic [15:0] v);
        @(posedge clk_sys);
        temp_value <= v;
        temp_valid <= 1'b1;
        @(posedge clk_sys);
        temp_valid <= 1'b0;
    endtask
    task heat(input logic [15:0] v, input logic e);
        tmp(v);
        rd(`HTC_A_STATUS, {31'h0, e}, 32'h1);
    endtask
    // long enough for a partly old frame to pass and a whole new one to follow
    task gate(input logic [3:0] e);
        repeat (450) @(posedge clk_sys);
        chk("tenths on", {28'h0, e}, {28'h0, on_cnt});
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`HTC_A_RATIO, 32'h100, 32'hFFFF);
        rd(`HTC_A_SLOPE, 32'h5, 32'hF);
        rd(`HTC_A_CTRL, 32'h0, 32'h7F);
        wr(`HTC_A_SETPT, 32'h3E8);
        rd(`HTC_A_STATUS, 32'h10, 32'h10);
        rd(`HTC_A_SETPT, 32'h0, 32'hFFFF);
        wr(`HTC_A_STATUS, 32'h10);
        rd(`HTC_A_STATUS, 32'h0, 32'h10);
        wr(`HTC_A_MODNUM, 32'h7);
        rd(`HTC_A_MODNUM, 32'h1, 32'hFFFF);
        rd(`HTC_A_STATUS, 32'h10, 32'h10);
        program_lock_switch <= 1'b1;
        wr(`HTC_A_SETPT, 32'h3E8);
        rd(`HTC_A_SETPT, 32'h3E8, 32'hFFFF);
        heat(16'h3DE, 1'b1);
        heat(16'h3F2, 1'b0);
        gate(4'h0);
        wr(`HTC_A_DBAND, 32'h14);
        heat(16'h3CA, 1'b1);
        heat(16'h3F2, 1'b1);
        gate(4'hA);
        heat(16'h401, 1'b0);
        heat(16'h3DE, 1'b0);
        heat(16'h3CF, 1'b1);
        wr(`HTC_A_CTRL, 32'h1);
        for (i = 0; i < 7; i++) begin
            tmp(16'(16'h3E8 - er[i]));
            rd(`HTC_A_STATUS, 32'(dt[i] << 8), 32'hF00);
        end
        tmp(16'h3E6);
        gate(4'h4);
        wr(`HTC_A_CTRL, 32'h2);
        tmp(16'h3CF);
        gate(4'h0);
        bypass_input <= 1'b1;
        gate(4'hA);
        wr(`HTC_A_CTRL, 32'h6);
        tmp(16'h401);
        gate(4'hA);
        bypass_input <= 1'b0;
        gate(4'h0);
        wr(`HTC_A_CTRL, 32'h0);
        tmp(16'h3CF);
        gate(4'hA);
        current_value <= 16'h96;
        wr(`HTC_A_HILVL, 32'h64);
        repeat (20) @(posedge clk_sys);
        rd(`HTC_A_STATUS, 32'h2, 32'h2);
        chk("contact", 32'h1, {31'h0, alarm_contact_ff});
        chk("alarm lamp", 32'h1, {31'h0, alarm_lamp_ff});
        wr(`HTC_A_CTRL, 32'h30);
        repeat (3) @(posedge clk_sys);
        chk("contact", 32'h0, {31'h0, alarm_contact_ff});
        chk("alarm lamp", 32'h0, {31'h0, alarm_lamp_ff});
        current_value <= 16'h32;
        repeat (20) @(posedge clk_sys);
        rd(`HTC_A_STATUS, 32'h0, 32'h2);
        addr_change_switch <= 1'b1;
        wr(`HTC_A_MODNUM, 32'h7);
        rd(`HTC_A_MODNUM, 32'h7, 32'hFFFF);
        chk("addr lamp", 32'h1, {31'h0, addr_window_lamp});
        repeat (60) @(posedge clk_sys);
        chk("addr lamp", 32'h0, {31'h0, addr_window_lamp});
        addr_change_switch <= 1'b0;
        tx_active <= 1'b1;
        rx_active <= 1'b1;
        bypass_input <= 1'b1;
        @(posedge clk_sys);
        tx_active <= 1'b0;
        rx_active <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("lamps", 32'h7, {29'h0, tx_activity_lamp, rx_activity_lamp, bypass_lamp_ff});
        wr(`HTC_A_CURVE_A, 32'h1);
        wr(`HTC_A_CTRL, 32'h8);
        tmp(16'h1F4);
        rd(`HTC_A_RATIO, 32'h200, 32'hFFFF);
        // hours two to four use a fixed error size with a random sign
        for (k = 0; k < 3; k++) begin
            wait (cyc >= (k + 1) * HOUR + 200);
            for (i = 0; i < 20; i++) begin
                tmp(16'(16'h3E8 + ((($random(seed) & 1) != 0) ? he[k] : -he[k])));
                repeat (40) @(posedge clk_sys);
            end
            wait (cyc >= (k + 2) * HOUR + 100);
            rd(`HTC_A_SLOPE, 32'(hs[k]), 32'hF);
            rd(`HTC_A_MEANERR, 32'(he[k]), 32'hFFFF);
        end
        repeat (20) @(posedge clk_sys);
        results;
    end
endmodule
